// ---- pkg/pmar_map.vh ----
// Register offsets, reset values and field positions for the power/alarm register bank
`ifndef PMAR_MAP_VH
`define PMAR_MAP_VH

`define PMAR_ADDR_W 12
`define PMAR_OFS_PROFILE_B 12'h29a
`define PMAR_OFS_PROFILE_C 12'h29b
`define PMAR_OFS_PROFILE_D 12'h29c
`define PMAR_OFS_ALARM_SUMMARY 12'h2c0
`define PMAR_OFS_ALARM_STATUS 12'h2c1
`define PMAR_OFS_ALARM_MASK 12'h2c2
`define PMAR_OFS_LANE_ALARM 12'h2c4

`define PMAR_RST_PROFILE_B 8'h0f
`define PMAR_RST_PROFILE_C 8'h04
`define PMAR_RST_PROFILE_D 8'h1b
`define PMAR_RST_ALARM_STATUS 8'h3f
`define PMAR_RST_ALARM_MASK 8'h3f
`define PMAR_RST_LANE_ALARM 8'hff

`define PMAR_LP_CODE_B 8'h06
`define PMAR_HP_CODE_B 8'h0f
`define PMAR_LP_CODE_C 8'h00
`define PMAR_HP_CODE_C 8'h04
`define PMAR_LP_CODE_D 8'h14
`define PMAR_HP_CODE_D 8'h1b

`define PMAR_BIT_BUFFER 5
`define PMAR_BIT_SPLL 4
`define PMAR_BIT_LINK 3
`define PMAR_BIT_REALIGN 2
`define PMAR_BIT_RSVD1 1
`define PMAR_BIT_DIVIDER 0
`define PMAR_ALARM_IMPL 8'h3f

`endif

// ---- logic/pmar_sticky_bit.v ----
// One sticky write-one-to-clear alarm flag, set wins over clear
`timescale 1ns/1ps
`default_nettype none

module pmar_sticky_bit #(
  parameter RST_VAL = 1'b1
) (
  // Clock and reset
  input wire clock,
  input wire sys_rst,
  input wire clk_en,
  // Control
  input wire set_in,
  input wire clr_in,
  // State
  output reg flag_r
);

  // Set beats clear so a fault present during the clearing write stays visible
  always @(posedge clock) begin
    if (sys_rst) begin
      flag_r <= RST_VAL;
    end else if (clk_en) begin
      if (set_in) begin
        flag_r <= 1'b1;
      end else if (clr_in) begin
        flag_r <= 1'b0;
      end
    end
  end

endmodule // pmar_sticky_bit

`default_nettype wire

// ---- logic/pmar_regs.v ----
// Power-profile and alarm aggregation register bank
//
// What this block does
// - Profile B decodes 0x06 low power, 0x0F high performance (reset).
// - Profile C decodes 0x00 low power, 0x04 high performance (reset).
// - Profile D decodes 0x14 low power, 0x1B high performance (reset).
// - Summary bit 0 is OR of unmasked status bits other than reserved bit 1; bits 7:1 zero.
// - Selector routes summary alarm onto the status output pin.
// - Status bits: buffer 5, pll 4, link 3, realign 2, divider 0; reset 0x3F.
// - Buffer alarm sets on any active lane overflow or underflow.
// - Writing 1 clears a status bit; writing 0 leaves it.
// - Per-lane record shows which lane buffer faulted.
// - Lane bit sets on its fault, W1C, all cleared by buffer-alarm clear.
// - Mask register mirrors status layout, bits reset to 1.
// - After reset every alarm status bit reads 1.
// - PLL alarm sets while serializer PLL unlocked; W1C.
`timescale 1ns/1ps
`default_nettype none
`include "pmar_map.vh"

module pmar_regs #(
  parameter LANES = 8,
  parameter ADDR_W = `PMAR_ADDR_W
) (
  // Clock, reset, enable
  input wire clock,
  input wire sys_rst,
  input wire clk_en,
  // Register access from the serial programming port
  input wire reg_wr,
  input wire reg_rd,
  input wire [ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_r,
  // Alarm sources
  input wire [LANES-1:0] lane_active,
  input wire [LANES-1:0] lane_overflow,
  input wire [LANES-1:0] lane_underflow,
  input wire spll_locked,
  input wire link_alarm_evt,
  input wire realign_evt,
  input wire divider_mismatch,
  // Status pin routing
  input wire status_sel_alarm,
  input wire cal_status_in,
  output reg status_output_pin_r,
  // Decoded power mode
  output reg low_power_mode_r,
  output reg high_perf_mode_r,
  output reg profile_mixed_r
);

  reg [7:0] profile_code_b_r;
  reg [7:0] profile_code_c_r;
  reg [7:0] profile_code_d_r;
  reg [7:0] mask_r;
  wire [7:0] status_w;
  wire [LANES-1:0] lane_flag_w;
  wire [LANES-1:0] lane_fault_w;
  wire [LANES-1:0] lane_clr_w;
  wire [7:0] lane_rd_w;
  wire [5:0] status_set_w;
  wire [5:0] status_clr_w;
  wire [7:0] alarm_vec_w;
  wire wr_status;
  wire wr_lane;
  wire alarm_any;
  wire lp_b;
  wire lp_c;
  wire lp_d;
  wire hp_b;
  wire hp_c;
  wire hp_d;
  wire lp_all;
  wire hp_all;

  // Reset image of the status flags, handed to each flag below
  localparam [7:0] RST_STATUS = `PMAR_RST_ALARM_STATUS;
  // Bits allowed to reach the summary; reserved bit 1 is never an alarm
  localparam [7:0] ALARM_SRC = `PMAR_ALARM_IMPL & ~(8'h01 << `PMAR_BIT_RSVD1);

  // Address decodes for the write-one-to-clear registers
  assign wr_status = reg_wr && (reg_addr == `PMAR_OFS_ALARM_STATUS);
  assign wr_lane = reg_wr && (reg_addr == `PMAR_OFS_LANE_ALARM);

  // Only active lanes can raise a buffer fault
  assign lane_fault_w = lane_active & (lane_overflow | lane_underflow);

  // Set conditions; a persisting level re-arms its flag every cycle
  assign status_set_w[`PMAR_BIT_BUFFER] = |lane_fault_w;
  assign status_set_w[`PMAR_BIT_SPLL] = !spll_locked;
  assign status_set_w[`PMAR_BIT_LINK] = link_alarm_evt;
  assign status_set_w[`PMAR_BIT_REALIGN] = realign_evt;
  assign status_set_w[`PMAR_BIT_RSVD1] = 1'b0;
  assign status_set_w[`PMAR_BIT_DIVIDER] = divider_mismatch;
  // One clear strobe per status bit; a written 0 leaves its flag alone
  assign status_clr_w = {6{wr_status}} & reg_wdata[5:0];

  // Lane clears; lanes past bit 7 have no bit of their own in the register
  genvar gi;
  generate
    for (gi = 0; gi < LANES; gi = gi + 1) begin : g_lane
      if (gi < 8) begin : g_own
        assign lane_clr_w[gi] = (wr_lane && reg_wdata[gi]) ||
                                status_clr_w[`PMAR_BIT_BUFFER];
      end else begin : g_wide
        assign lane_clr_w[gi] = status_clr_w[`PMAR_BIT_BUFFER];
      end
      // Per-lane record, so software can find the lane that faulted
      pmar_sticky_bit #(
        .RST_VAL(1'b1)
      ) u_lane (
        .clock(clock),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .set_in(lane_fault_w[gi]),
        .clr_in(lane_clr_w[gi]),
        .flag_r(lane_flag_w[gi])
      );
    end
  endgenerate

  // Eight-bit lane view; lanes that are not built read as zero
  genvar gr;
  generate
    for (gr = 0; gr < 8; gr = gr + 1) begin : g_lane_rd
      if (gr < LANES) begin : g_real
        assign lane_rd_w[gr] = lane_flag_w[gr];
      end else begin : g_none
        assign lane_rd_w[gr] = 1'b0;
      end
    end
  endgenerate

  // Status flags, all reset to 1 and W1C with set priority
  pmar_sticky_bit #(.RST_VAL(RST_STATUS[`PMAR_BIT_BUFFER])) u_buf (
    .clock(clock),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .set_in(status_set_w[`PMAR_BIT_BUFFER]),
    .clr_in(status_clr_w[`PMAR_BIT_BUFFER]),
    .flag_r(status_w[`PMAR_BIT_BUFFER])
  );

  pmar_sticky_bit #(.RST_VAL(RST_STATUS[`PMAR_BIT_SPLL])) u_spll (
    .clock(clock),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .set_in(status_set_w[`PMAR_BIT_SPLL]),
    .clr_in(status_clr_w[`PMAR_BIT_SPLL]),
    .flag_r(status_w[`PMAR_BIT_SPLL])
  );

  pmar_sticky_bit #(.RST_VAL(RST_STATUS[`PMAR_BIT_LINK])) u_link (
    .clock(clock),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .set_in(status_set_w[`PMAR_BIT_LINK]),
    .clr_in(status_clr_w[`PMAR_BIT_LINK]),
    .flag_r(status_w[`PMAR_BIT_LINK])
  );

  pmar_sticky_bit #(.RST_VAL(RST_STATUS[`PMAR_BIT_REALIGN])) u_realign (
    .clock(clock),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .set_in(status_set_w[`PMAR_BIT_REALIGN]),
    .clr_in(status_clr_w[`PMAR_BIT_REALIGN]),
    .flag_r(status_w[`PMAR_BIT_REALIGN])
  );

  // Reserved bit 1 has no source; resets to 1 and is W1C like its neighbours
  pmar_sticky_bit #(.RST_VAL(RST_STATUS[`PMAR_BIT_RSVD1])) u_rsvd (
    .clock(clock),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .set_in(status_set_w[`PMAR_BIT_RSVD1]),
    .clr_in(status_clr_w[`PMAR_BIT_RSVD1]),
    .flag_r(status_w[`PMAR_BIT_RSVD1])
  );

  pmar_sticky_bit #(.RST_VAL(RST_STATUS[`PMAR_BIT_DIVIDER])) u_div (
    .clock(clock),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .set_in(status_set_w[`PMAR_BIT_DIVIDER]),
    .clr_in(status_clr_w[`PMAR_BIT_DIVIDER]),
    .flag_r(status_w[`PMAR_BIT_DIVIDER])
  );
  assign status_w[7:6] = 2'h0;

  // Unmasked alarms; the mask never touches the flags themselves
  assign alarm_vec_w = status_w & ~mask_r & ALARM_SRC;
  // Summary is a live OR, so it drops as soon as the last flag clears
  assign alarm_any = |alarm_vec_w;

  // Writable registers: profiles and mask
  always @(posedge clock) begin
    if (sys_rst) begin
      profile_code_b_r <= `PMAR_RST_PROFILE_B;
      profile_code_c_r <= `PMAR_RST_PROFILE_C;
      profile_code_d_r <= `PMAR_RST_PROFILE_D;
      mask_r <= `PMAR_RST_ALARM_MASK;
    end else if (clk_en && reg_wr) begin
      // Reserved codes are stored as written; software must avoid them
      case (reg_addr)
        `PMAR_OFS_PROFILE_B: begin
          profile_code_b_r <= reg_wdata;
        end
        `PMAR_OFS_PROFILE_C: begin
          profile_code_c_r <= reg_wdata;
        end
        `PMAR_OFS_PROFILE_D: begin
          profile_code_d_r <= reg_wdata;
        end
        `PMAR_OFS_ALARM_MASK: begin
          // Bits 7:6 are kept as written; they gate nothing
          mask_r <= reg_wdata;
        end
        default: begin
          mask_r <= mask_r;
        end
      endcase
    end
  end

  // Mode decode per register
  assign lp_b = (profile_code_b_r == `PMAR_LP_CODE_B);
  assign hp_b = (profile_code_b_r == `PMAR_HP_CODE_B);
  assign lp_c = (profile_code_c_r == `PMAR_LP_CODE_C);
  assign hp_c = (profile_code_c_r == `PMAR_HP_CODE_C);
  assign lp_d = (profile_code_d_r == `PMAR_LP_CODE_D);
  assign hp_d = (profile_code_d_r == `PMAR_HP_CODE_D);
  // Whole-set agreement; one register left in the other mode counts as neither
  assign lp_all = lp_b && lp_c && lp_d;
  assign hp_all = hp_b && hp_c && hp_d;

  // Mode outputs; a mixed or reserved set is flagged rather than guessed
  // Profile A sits outside this bank, so only B, C and D are weighed here
  always @(posedge clock) begin
    if (sys_rst) begin
      low_power_mode_r <= 1'b0;
      high_perf_mode_r <= 1'b1;
      profile_mixed_r <= 1'b0;
    end else if (clk_en) begin
      low_power_mode_r <= lp_all;
      high_perf_mode_r <= hp_all;
      profile_mixed_r <= !(lp_all || hp_all);
    end
  end

  // Status pin: alarm or calibration status, registered for a clean pin
  // The pin trails the summary bit by one cycle; glitch-free is worth it
  always @(posedge clock) begin
    if (sys_rst) begin
      status_output_pin_r <= 1'b0;
    end else if (clk_en) begin
      status_output_pin_r <= status_sel_alarm ? alarm_any : cal_status_in;
    end
  end

  // Read data, one cycle after the strobe; unmapped reads return zero
  // Flags are registered, so one set in the read cycle shows only on the next read
  always @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata_r <= 8'h00;
    end else if (clk_en && reg_rd) begin
      case (reg_addr)
        `PMAR_OFS_PROFILE_B: begin
          reg_rdata_r <= profile_code_b_r;
        end
        `PMAR_OFS_PROFILE_C: begin
          reg_rdata_r <= profile_code_c_r;
        end
        `PMAR_OFS_PROFILE_D: begin
          reg_rdata_r <= profile_code_d_r;
        end
        `PMAR_OFS_ALARM_SUMMARY: begin
          reg_rdata_r <= {7'h00, alarm_any};
        end
        `PMAR_OFS_ALARM_STATUS: begin
          reg_rdata_r <= status_w;
        end
        `PMAR_OFS_ALARM_MASK: begin
          reg_rdata_r <= mask_r;
        end
        `PMAR_OFS_LANE_ALARM: begin
          reg_rdata_r <= lane_rd_w;
        end
        default: begin
          reg_rdata_r <= 8'h00;
        end
      endcase
    end
  end

endmodule // pmar_regs

`default_nettype wire

// ---- dv/pmar_regs_checker.sv ----
// Assertion checker for the power/alarm register bank
`timescale 1ns/1ps
`default_nettype none
`include "pmar_map.vh"
module pmar_regs_checker #(parameter LANES = 8, parameter ADDR_W = 12) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_r,
  // Alarm sources and pin
  input wire logic [LANES-1:0] lane_active,
  input wire logic [LANES-1:0] lane_overflow,
  input wire logic spll_locked,
  input wire logic divider_mismatch,
  input wire logic status_sel_alarm,
  input wire logic cal_status_in,
  input wire logic status_output_pin_r
);
  localparam [11:0] SU = `PMAR_OFS_ALARM_SUMMARY;
  localparam [11:0] ST = `PMAR_OFS_ALARM_STATUS;
  localparam [11:0] LN = `PMAR_OFS_LANE_ALARM;
  localparam [11:0] PC = `PMAR_OFS_PROFILE_C;
  // Lone accesses only, so a mixed read/write never muddles the answer
  wire rd_go = clk_en && reg_rd && !reg_wr;
  wire wr_go = clk_en && reg_wr && !reg_rd;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  pin_passthru_a: assert property (clk_en && !status_sel_alarm |=>
    status_output_pin_r == $past(cal_status_in)) else $error("pin lost cal status");
  pin_alarm_a: assert property (rd_go && reg_addr == SU && status_sel_alarm |=>
    reg_rdata_r[0] == status_output_pin_r) else $error("pin differs from summary");
  sum_rsvd_a: assert property (rd_go && reg_addr == SU |=>
    reg_rdata_r[7:1] == 7'h00) else $error("summary upper bits set");
  st_rsvd_a: assert property (rd_go && reg_addr == ST |=>
    reg_rdata_r[7:6] == 2'h0) else $error("status upper bits set");
  pll_set_a: assert property (clk_en && !spll_locked ##1 rd_go && reg_addr == ST |=>
    reg_rdata_r[4]) else $error("pll alarm not set");
  set_wins_a: assert property (wr_go && reg_addr == ST && reg_wdata[0] && divider_mismatch
    ##1 rd_go && reg_addr == ST |=> reg_rdata_r[0]) else $error("clear beat set");
  lane_set_a: assert property (clk_en && lane_active[0] && lane_overflow[0]
    ##1 rd_go && reg_addr == LN |=> reg_rdata_r[0]) else $error("lane 0 not set");
  prof_rw_a: assert property (wr_go && reg_addr == PC ##1 rd_go && reg_addr == PC |=>
    reg_rdata_r == $past(reg_wdata, 2)) else $error("profile readback wrong");
  // Main scenarios
  cover property (rd_go && reg_addr == SU ##1 reg_rdata_r[0]);
  cover property (status_sel_alarm && status_output_pin_r);
  cover property (wr_go && reg_addr == ST && divider_mismatch);
endmodule // pmar_regs_checker
bind pmar_regs pmar_regs_checker #(.LANES(LANES), .ADDR_W(ADDR_W)) u_chk (.clock, .sys_rst,
  .clk_en, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_r, .lane_active, .lane_overflow,
  .spll_locked, .divider_mismatch, .status_sel_alarm, .cal_status_in, .status_output_pin_r);
`default_nettype wire

// ---- dv/pmar_regs_tb.sv ----
// Self-checking bench for the power/alarm register bank
`timescale 1ns/1ps
`default_nettype none
`include "pmar_map.vh"
module pmar_regs_tb;
  localparam [11:0] SU = `PMAR_OFS_ALARM_SUMMARY;
  localparam [11:0] ST = `PMAR_OFS_ALARM_STATUS;
  localparam [11:0] MK = `PMAR_OFS_ALARM_MASK;
  localparam [11:0] LN = `PMAR_OFS_LANE_ALARM;
  localparam [11:0] PB = `PMAR_OFS_PROFILE_B;
  localparam [11:0] PC = `PMAR_OFS_PROFILE_C;
  localparam [11:0] PD = `PMAR_OFS_PROFILE_D;
  // Stimulus and observed outputs
  logic clock = 0, sys_rst = 1, clk_en = 1, reg_wr = 0, reg_rd = 0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata_r;
  logic [7:0] lane_active = 8'hff, lane_overflow = 8'h00, lane_underflow = 8'h00;
  logic spll_locked = 1, link_alarm_evt = 0, realign_evt = 0, divider_mismatch = 0;
  logic status_sel_alarm = 1, cal_status_in = 0, status_output_pin_r;
  logic low_power_mode_r, high_perf_mode_r, profile_mixed_r;
  int fail_count = 0, cmp_count = 0;
  pmar_regs dut (.clock, .sys_rst, .clk_en, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata_r, .lane_active, .lane_overflow, .lane_underflow, .spll_locked,
    .link_alarm_evt, .realign_evt, .divider_mismatch, .status_sel_alarm, .cal_status_in,
    .status_output_pin_r, .low_power_mode_r, .high_perf_mode_r, .profile_mixed_r);
  // 200 MHz clock
  initial begin
    forever #2.5 clock = ~clock;
  end
  // Inputs move 1 ns after the edge, clear of sampling
  task automatic tick;
    @(posedge clock);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Strobes stay up between chained accesses; idle drops them
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_rd = 0;
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    tick;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    reg_wr = 0;
    reg_rd = 1;
    reg_addr = a;
    tick;
    chk(reg_rdata_r, e);
  endtask
  task automatic idle;
    reg_wr = 0;
    reg_rd = 0;
    tick;
  endtask
  task automatic modes(input logic [7:0] e);
    chk({5'h00, low_power_mode_r, high_perf_mode_r, profile_mixed_r}, e);
  endtask
  // Drive one alarm source; bit 5 faults lane 0
  task automatic set_src(input int b, input logic v);
    case (b)
      5: lane_overflow[0] = v;
      4: spll_locked = !v;
      3: link_alarm_evt = v;
      2: realign_evt = v;
      default: divider_mismatch = v;
    endcase
  endtask
  task automatic t_reset;
    sys_rst = 1;
    repeat (10) tick;
    sys_rst = 0;
    rd(PB, 8'h0f);
    rd(PC, 8'h04);
    rd(PD, 8'h1b);
    rd(ST, 8'h3f);
    rd(MK, 8'h3f);
    rd(LN, 8'hff);
    wr(SU, 8'hff);
    rd(SU, 8'h00);
    idle;
    modes(8'h02);
    chk({7'h00, status_output_pin_r}, 8'h00);
  endtask
  // All units written together, with cal and link enables off outside this block
  // Calibration after each switch is run outside this block
  task automatic t_modes;
    wr(PB, 8'h06);
    wr(PD, 8'h14);
    wr(PC, 8'h00);
    rd(PC, 8'h00);
    modes(8'h04);
    wr(PC, 8'h02);
    rd(PC, 8'h02);
    idle;
    modes(8'h01);
    wr(PB, 8'h0f);
    wr(PD, 8'h1b);
    wr(PC, 8'h04);
    rd(PC, 8'h04);
    modes(8'h02);
  endtask
  task automatic t_alarms;
    int bits[5] = '{5, 4, 3, 2, 0};
    logic [7:0] m;
    wr(ST, 8'hff);
    rd(ST, 8'h00);
    rd(LN, 8'h00);
    foreach (bits[i]) begin
      m = 8'h01 << bits[i];
      set_src(bits[i], 1);
      idle;
      set_src(bits[i], 0);
      if (bits[i] == 5) rd(LN, 8'h01);
      rd(ST, m);
      wr(ST, 8'h00);
      rd(SU, 8'h00);
      wr(MK, 8'h3f ^ m);
      rd(SU, 8'h01);
      chk({7'h00, status_output_pin_r}, 8'h01);
      rd(ST, m);
      wr(ST, m);
      rd(SU, 8'h00);
      chk({7'h00, status_output_pin_r}, 8'h00);
      rd(LN, 8'h00);
      wr(MK, 8'h3f);
    end
    idle;
  endtask
  // A fault still present during the clearing write keeps its bit
  task automatic t_set_wins;
    divider_mismatch = 1;
    lane_underflow[6] = 1;
    idle;
    wr(ST, 8'h01);
    rd(ST, 8'h21);
    wr(LN, 8'h40);
    rd(LN, 8'h40);
    divider_mismatch = 0;
    lane_underflow[6] = 0;
    wr(ST, 8'h01);
    wr(LN, 8'h40);
    rd(LN, 8'h00);
    rd(ST, 8'h20);
    // A fault on an inactive lane raises nothing
    wr(ST, 8'h20);
    lane_active[6] = 0;
    lane_underflow[6] = 1;
    idle;
    rd(ST, 8'h00);
    rd(LN, 8'h00);
    lane_underflow[6] = 0;
    lane_active[6] = 1;
    status_sel_alarm = 0;
    cal_status_in = 1;
    idle;
    chk({7'h00, status_output_pin_r}, 8'h01);
    status_sel_alarm = 1;
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog well past the roughly 120 cycles the tests need
  initial begin
    repeat (5000) @(posedge clock);
    fail_count++;
    report_and_stop;
  end
  initial begin
    t_reset;
    t_modes;
    t_alarms;
    t_set_wins;
    t_reset;
    report_and_stop;
  end
endmodule // pmar_regs_tb
`default_nettype wire
